// >>> src/btse_pkg.sv
// Constants, opcodes, field positions and state codes for the bit toggle / skip unit.
// Assumes a 24-bit instruction word and a 16-bit data path inside the core.
//
// How it works
// [RULE1] File toggle flips only the chosen bit, writes it back, flags untouched.
// [RULE2] File toggle opcode is 1010 1010 in the top byte.
// [RULE3] File addresses span 0..8191; word accesses use even addresses only.
// [RULE4] Software keeps bit position within 0..7 for bytes, 0..15 for words.
// [RULE5] Byte suffix selects byte width; otherwise full 16-bit word.
// [RULE6] Software gives word-aligned file addresses in word mode.
// [RULE7] Toggle also works on a working register, direct or indirect.
// [RULE8] Register toggle opcode 1010 0010; four-bit position; width bit 1 means byte.
// [RULE9] Three-bit mode field picks addressing; four-bit field picks one of sixteen registers.
// [RULE10] Extended data space indirect addresses use the read page register.
// [RULE11] Tested bit clear: drop fetched next instruction, run a no-op instead.
// [RULE12] Skip test never modifies the operand nor the status flags.
// [RULE13] Register skip opcode 1010 0111, word only, positions 0..15.
// [RULE14] Skip takes one cycle without skipping, two or three when skipping. Memory operand forms add the cycles spent waiting for i_rd_valid.
// [RULE15] Bit 0 is the least significant bit.
// [RULE16] Reads of slow peripheral registers may stretch the cycle count.
// [RULE17] Register skip supports indirect addressing with pointer update.
// [RULE18] Skipping a two-word instruction costs three cycles, a one-word one two.
// [RULE19] Each instruction is one program word; toggles finish in one cycle. Only the direct register form does; memory forms wait for i_rd_valid.

package btse_pkg;

  // ==========================================================================
  // Widths
  localparam int INSTR_W = 24;
  localparam int DATA_W  = 16;
  localparam int FADDR_W = 13;
  localparam int BIT_W   = 4;
  localparam int REG_W   = 4;
  localparam int MODE_W  = 3;

  // ==========================================================================
  // Opcodes in the top byte
  localparam logic [7:0] OP_TOG_FILE = 8'haa;
  localparam logic [7:0] OP_TOG_WREG = 8'ha2;
  localparam logic [7:0] OP_SKC_FILE = 8'haf;
  localparam logic [7:0] OP_SKC_WREG = 8'ha7;

  // ==========================================================================
  // Field positions
  localparam int OPC_LSB   = 16;
  localparam int WBIT_LSB  = 12;
  localparam int FBIT_LSB  = 13;
  localparam int FBIT_W    = 3;
  localparam int FADDR_LSB = 1;
  localparam int FADDR_MSB = 12;
  localparam int FPOS_HI   = 0;
  localparam int WIDTH_POS = 10;
  localparam int MODE_LSB  = 4;
  localparam int REG_LSB   = 0;

  // ==========================================================================
  // Addressing modes
  localparam logic [2:0] AM_DIRECT  = 3'h0;
  localparam logic [2:0] AM_IND     = 3'h1;
  localparam logic [2:0] AM_POSTDEC = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC  = 3'h4;
  localparam logic [2:0] AM_PREINC  = 3'h5;

  // ==========================================================================
  // Byte enables, pointer steps, skip lengths
  localparam logic [1:0]  BE_WORD   = 2'h3;
  localparam logic [1:0]  BE_LO     = 2'h1;
  localparam logic [1:0]  BE_HI     = 2'h2;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] BIT_ONE   = 16'h0001;
  localparam logic [1:0]  SKIP_ONE  = 2'h1;
  localparam logic [1:0]  SKIP_TWO  = 2'h2;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SKIP = 3'b100
  } btse_state_t;

endpackage : btse_pkg

// >>> src/btse_addr_gen.sv
// Effective address and pointer update for working-register operands.
// Assumes the register value is presented combinationally with the mode.
`timescale 1ns/1ps
`default_nettype none

module btse_addr_gen #(
  parameter int PAGE_W = 10,
  parameter bit EXT_DS = 1'b1
) (
  // Operand selection
  input  wire logic [2:0]          i_mode,
  input  wire logic                i_byte,
  input  wire logic [15:0]         i_source_work_register,
  input  wire logic [PAGE_W-1:0]   i_data_read_page_register,
  // Results
  output logic [PAGE_W+14:0]       o_ea,
  output logic [15:0]              o_ptr_next,
  output logic                     o_ptr_we
);

  logic [15:0] step;
  logic [15:0] eff;

  always_comb
  begin
    step       = i_byte ? btse_pkg::STEP_BYTE : btse_pkg::STEP_WORD;
    eff        = i_source_work_register;
    o_ptr_next = i_source_work_register;
    o_ptr_we   = 1'b0;
    case (i_mode) // [RULE9] [RULE17]
      btse_pkg::AM_DIRECT, btse_pkg::AM_IND:
      begin
        o_ptr_we = 1'b0;
      end
      btse_pkg::AM_POSTDEC:
      begin
        o_ptr_next = i_source_work_register - step;
        o_ptr_we   = 1'b1;
      end
      btse_pkg::AM_POSTINC:
      begin
        o_ptr_next = i_source_work_register + step;
        o_ptr_we   = 1'b1;
      end
      btse_pkg::AM_PREDEC:
      begin
        o_ptr_next = i_source_work_register - step;
        eff        = o_ptr_next;
        o_ptr_we   = 1'b1;
      end
      btse_pkg::AM_PREINC:
      begin
        o_ptr_next = i_source_work_register + step;
        eff        = o_ptr_next;
        o_ptr_we   = 1'b1;
      end
      default:
      begin
        o_ptr_we = 1'b0;
      end
    endcase
    // Upper half of the data space is paged
    if (EXT_DS && eff[15]) // [RULE10]
      o_ea = {i_data_read_page_register, eff[14:0]};
    else
      o_ea = {{(PAGE_W-1){1'b0}}, eff};
  end

endmodule : btse_addr_gen

`default_nettype wire

// >>> src/btse_exec.sv
// Execute logic for the bit toggle and skip-if-bit-clear instructions.
// Assumes the register file presents the register named by the ssss field
// in the same cycle as the instruction, and data memory answers with i_rd_valid.
`timescale 1ns/1ps
`default_nettype none

module btse_exec #(
  parameter int PAGE_W = 10,
  parameter bit EXT_DS = 1'b1
) (
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  // Instruction from fetch
  input  wire logic                i_instr_valid,
  input  wire logic [23:0]         i_instr,
  input  wire logic [15:0]         i_source_work_register,
  input  wire logic                i_next_two_word,
  input  wire logic [PAGE_W-1:0]   i_data_read_page_register,
  output logic                     o_ready,
  // Data memory read
  output logic                     o_rd_req,
  output logic [PAGE_W+14:0]       o_rd_addr,
  input  wire logic                i_rd_valid,
  input  wire logic [15:0]         i_rd_data,
  // Data memory write
  output logic                     o_wr_en,
  output logic [PAGE_W+14:0]       o_wr_addr,
  output logic [1:0]               o_wr_be,
  output logic [15:0]              o_wr_data,
  // Working register write
  output logic                     o_wreg_we,
  output logic [3:0]               o_wreg_sel,
  output logic [15:0]              o_wreg_data,
  // Pointer update
  output logic                     o_ptr_we,
  output logic [3:0]               o_ptr_sel,
  output logic [15:0]              o_ptr_data,
  // Squash of the fetched next instruction
  output logic                     o_squash
);

  localparam int EA_W = PAGE_W + 15;

  // ==========================================================================
  // Parameter check
  generate
    if (PAGE_W < 2)
    begin : g_bad_page
      $error("PAGE_W must be at least 2");
    end
  endgenerate

  // ==========================================================================
  // Decode
  logic [7:0]      opcode;
  logic            bit_toggle_op;
  logic            skip_if_bit_clear_op;
  logic            is_wform;
  logic            hit;
  logic            byte_mode;
  logic [2:0]      mode;
  logic            direct;
  logic [3:0]      bit_position_operand;
  logic [EA_W-1:0] ea_w;
  logic [EA_W-1:0] ea;
  logic [15:0]     ptr_next;
  logic            ptr_we;
  logic [3:0]      pos_new;
  logic [1:0]      be_new;
  logic            accept;

  assign opcode = i_instr[btse_pkg::OPC_LSB +: 8];
  assign bit_toggle_op = (opcode == btse_pkg::OP_TOG_FILE) // [RULE2]
                       | (opcode == btse_pkg::OP_TOG_WREG); // [RULE8]
  assign skip_if_bit_clear_op = (opcode == btse_pkg::OP_SKC_FILE)
                              | (opcode == btse_pkg::OP_SKC_WREG); // [RULE13]
  assign is_wform  = (opcode == btse_pkg::OP_TOG_WREG) | (opcode == btse_pkg::OP_SKC_WREG);
  assign hit       = bit_toggle_op | skip_if_bit_clear_op;
  // Skip on a register is word only
  assign byte_mode = (opcode == btse_pkg::OP_TOG_WREG) & i_instr[btse_pkg::WIDTH_POS]; // [RULE5]
  assign mode      = i_instr[btse_pkg::MODE_LSB +: btse_pkg::MODE_W];
  assign direct    = is_wform & (mode == btse_pkg::AM_DIRECT);
  assign accept    = i_instr_valid & o_ready & hit;

  btse_addr_gen #(
    .PAGE_W (PAGE_W),
    .EXT_DS (EXT_DS)
  ) u_addr_gen (
    .i_mode                    (mode),
    .i_byte                    (byte_mode),
    .i_source_work_register    (i_source_work_register),
    .i_data_read_page_register (i_data_read_page_register),
    .o_ea                      (ea_w),
    .o_ptr_next                (ptr_next),
    .o_ptr_we                  (ptr_we)
  );

  always_comb
  begin
    bit_position_operand = i_instr[btse_pkg::WBIT_LSB +: btse_pkg::BIT_W];
    if (is_wform)
    begin
      ea = ea_w;
      if (!byte_mode)
      begin
        pos_new = bit_position_operand;
        be_new  = btse_pkg::BE_WORD;
      end
      else
      begin
        // Odd byte lives in the upper half of the word [RULE15]
        pos_new = {ea_w[0] & ~direct, bit_position_operand[2:0]};
        be_new  = ea_w[0] ? btse_pkg::BE_HI : btse_pkg::BE_LO;
      end
    end
    else
    begin
      // Byte form folds into a word access at the even address [RULE3]
      ea      = {{(EA_W-btse_pkg::FADDR_W){1'b0}},
                 i_instr[btse_pkg::FADDR_MSB:btse_pkg::FADDR_LSB], 1'b0};
      pos_new = {i_instr[btse_pkg::FPOS_HI], i_instr[btse_pkg::FBIT_LSB +: btse_pkg::FBIT_W]};
      be_new  = btse_pkg::BE_WORD;
    end
  end

  // ==========================================================================
  // Latched instruction
  logic            tog_q;
  logic [3:0]      pos_q;
  logic [1:0]      be_q;
  logic            wform_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      tog_q   <= 1'b0;
      pos_q   <= 4'h0;
      be_q    <= btse_pkg::BE_WORD;
      wform_q <= 1'b0;
    end
    else if (accept)
    begin
      tog_q   <= bit_toggle_op;
      pos_q   <= pos_new;
      be_q    <= be_new;
      wform_q <= is_wform;
    end
  end

  // ==========================================================================
  // Result of the test or toggle
  btse_pkg::btse_state_t state_q;
  btse_pkg::btse_state_t state_d;
  logic [1:0]      skip_left_q;
  logic [15:0]     operand;
  logic [3:0]      pos_now;
  logic            tog_now;
  logic            do_result;
  logic            tested;
  logic            skip_now;
  logic [15:0]     flipped;

  assign operand   = (state_q == btse_pkg::ST_WAIT) ? i_rd_data : i_source_work_register;
  assign pos_now   = (state_q == btse_pkg::ST_WAIT) ? pos_q : pos_new;
  assign tog_now   = (state_q == btse_pkg::ST_WAIT) ? tog_q : bit_toggle_op;
  assign do_result = (accept & direct) | ((state_q == btse_pkg::ST_WAIT) & i_rd_valid);
  assign tested    = operand[pos_now]; // [RULE15]
  assign skip_now  = do_result & ~tog_now & ~tested; // [RULE11]
  assign flipped   = operand ^ (btse_pkg::BIT_ONE << pos_now); // [RULE1] [RULE7]

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      btse_pkg::ST_IDLE:
      begin
        if (skip_now)
          state_d = btse_pkg::ST_SKIP;
        else if (accept && !direct)
          state_d = btse_pkg::ST_WAIT;
      end
      btse_pkg::ST_WAIT:
      begin
        // Slow peripherals simply hold this state [RULE16]
        if (skip_now)
          state_d = btse_pkg::ST_SKIP;
        else if (i_rd_valid)
          state_d = btse_pkg::ST_IDLE;
      end
      btse_pkg::ST_SKIP:
      begin
        if (skip_left_q == btse_pkg::SKIP_ONE)
          state_d = btse_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = btse_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      state_q <= btse_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      skip_left_q <= 2'h0;
    else if (skip_now)
      skip_left_q <= i_next_two_word ? btse_pkg::SKIP_TWO : btse_pkg::SKIP_ONE; // [RULE14] [RULE18]
    else if (state_q == btse_pkg::ST_SKIP)
      skip_left_q <= skip_left_q - btse_pkg::SKIP_ONE;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_ready  <= 1'b0;
      o_squash <= 1'b0;
    end
    else
    begin
      o_ready  <= (state_d == btse_pkg::ST_IDLE);
      o_squash <= (state_d == btse_pkg::ST_SKIP); // [RULE11]
    end
  end

  // ==========================================================================
  // Memory read and pointer update
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_rd_req   <= 1'b0;
      o_rd_addr  <= '0;
      o_ptr_we   <= 1'b0;
      o_ptr_sel  <= 4'h0;
      o_ptr_data <= 16'h0000;
    end
    else
    begin
      o_rd_req <= accept & ~direct;
      o_ptr_we <= accept & is_wform & ptr_we; // [RULE17]
      if (accept)
      begin
        o_rd_addr  <= ea;
        o_ptr_sel  <= i_instr[btse_pkg::REG_LSB +: btse_pkg::REG_W];
        o_ptr_data <= ptr_next;
      end
    end
  end

  // ==========================================================================
  // Write back; skip forms never write
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_wr_en     <= 1'b0;
      o_wr_addr   <= '0;
      o_wr_be     <= btse_pkg::BE_WORD;
      o_wr_data   <= 16'h0000;
      o_wreg_we   <= 1'b0;
      o_wreg_sel  <= 4'h0;
      o_wreg_data <= 16'h0000;
    end
    else
    begin
      o_wr_en   <= do_result & tog_now & (state_q == btse_pkg::ST_WAIT); // [RULE1] [RULE12]
      o_wreg_we <= accept & direct & bit_toggle_op; // [RULE7] [RULE19]
      if (do_result && tog_now && state_q == btse_pkg::ST_WAIT)
      begin
        o_wr_addr <= o_rd_addr;
        o_wr_be   <= be_q;
        o_wr_data <= flipped;
      end
      if (accept && direct && bit_toggle_op)
      begin
        o_wreg_sel  <= i_instr[btse_pkg::REG_LSB +: btse_pkg::REG_W];
        o_wreg_data <= flipped;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_toggle_one_bit: assert property (o_wr_en |-> $countones(o_wr_data ^ $past(i_rd_data)) == 1) // [RULE1]
    else $error("memory toggle changed other than one bit");
  a_wreg_one_bit: assert property (o_wreg_we |-> $countones(o_wreg_data ^ $past(i_source_work_register)) == 1) // [RULE7]
    else $error("register toggle changed other than one bit");
  a_skip_no_write: assert property (do_result && !tog_now |=> !o_wr_en && !o_wreg_we) // [RULE12]
    else $error("skip test wrote its operand");
  a_direct_one_cycle: assert property (accept && direct && bit_toggle_op |=> o_wreg_we && o_ready) // [RULE19]
    else $error("direct toggle did not finish in one cycle");
  a_skip_two_cycles: assert property (skip_now && !i_next_two_word |=> o_squash ##1 (!o_squash && o_ready)) // [RULE14]
    else $error("one-word skip length wrong");
  a_skip_three_cycles: assert property (skip_now && i_next_two_word |=> o_squash [*2] ##1 !o_squash) // [RULE18]
    else $error("two-word skip length wrong");
  a_set_no_skip: assert property (do_result && !tog_now && tested |=> !o_squash && o_ready) // [RULE11]
    else $error("set bit caused a skip");
  a_direct_no_ptr: assert property (accept && direct |=> !o_ptr_we && !o_rd_req) // [RULE9]
    else $error("direct mode touched pointer or memory");
  a_file_addr_even: assert property (o_rd_req && !wform_q |-> !o_rd_addr[0]) // [RULE3]
    else $error("file access address not even");
  a_read_wait_hold: assert property (state_q == btse_pkg::ST_WAIT && !i_rd_valid |=> !o_ready) // [RULE16]
    else $error("ready raised while read pending");

  c_mem_toggle: cover property (o_rd_req ##[1:4] o_wr_en);
  c_skip_one: cover property (skip_now && !i_next_two_word);
  c_skip_two: cover property (skip_now && i_next_two_word);
  c_ptr_update: cover property (o_ptr_we && o_rd_req);

endmodule : btse_exec

`default_nettype wire

// >>> sim/btse_mem_model.sv
// Data memory model that answers the execute unit's reads and takes its writes.
// Assumes byte addresses from the unit; only address bits 12:1 pick a word.
`timescale 1ns/1ps
`default_nettype none

module btse_mem_model #(
  parameter int EA_W = 25
) (
  // Clock
  input  wire logic            i_clock,
  // Read port
  input  wire logic            i_rd_req,
  input  wire logic [EA_W-1:0] i_rd_addr,
  input  wire logic [3:0]      i_lat,
  output logic                 o_rd_valid,
  output logic [15:0]          o_rd_data,
  // Write port
  input  wire logic            i_wr_en,
  input  wire logic [EA_W-1:0] i_wr_addr,
  input  wire logic [1:0]      i_wr_be,
  input  wire logic [15:0]     i_wr_data
);
  // ==========================================================================
  // Storage and read timing
  logic [15:0] mem [0:4095];
  logic [3:0]  cnt_q;
  logic [11:0] idx_q;

  initial
  begin
    o_rd_valid = 1'b0;
    o_rd_data  = 16'h5a5a;
    cnt_q      = 4'h0;
    idx_q      = 12'h000;
  end

  always @(negedge i_clock)
  begin
    if (cnt_q == 4'h1)
    begin
      o_rd_valid <= 1'b1;
      o_rd_data  <= mem[idx_q];
    end
    else
    begin
      // Data not held once the answer is over
      o_rd_valid <= 1'b0;
      o_rd_data  <= ~o_rd_data;
    end
    if (i_rd_req)
    begin
      cnt_q <= i_lat;
      idx_q <= i_rd_addr[12:1];
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    if (i_wr_en && i_wr_be[0])
      mem[i_wr_addr[12:1]][7:0] <= i_wr_data[7:0];
    if (i_wr_en && i_wr_be[1])
      mem[i_wr_addr[12:1]][15:8] <= i_wr_data[15:8];
  end

endmodule : btse_mem_model

`default_nettype wire

// >>> sim/test_bit_toggle_skip_exec.sv
// Self-checking bench for the bit toggle and skip-if-bit-clear execute unit.
// Assumes btse_exec with default parameters and btse_mem_model as data memory.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end

module test_bit_toggle_skip_exec;
  localparam int EA_W = 25;
  typedef struct packed {
    logic ok; logic mem; logic skp; logic ptr; logic clr;
    logic [EA_W-1:0] addr; logic [1:0] be; logic [15:0] wdat; logic [15:0] pdat;
  } btse_exp_t;

  logic            i_clock, i_rst_n, i_instr_valid, i_next_two_word, i_rd_valid;
  logic [23:0]     i_instr;
  logic [15:0]     i_source_work_register, i_rd_data;
  logic [9:0]      i_data_read_page_register;
  logic            o_ready, o_rd_req, o_wr_en, o_wreg_we, o_ptr_we, o_squash;
  logic [EA_W-1:0] o_rd_addr, o_wr_addr;
  logic [1:0]      o_wr_be;
  logic [15:0]     o_wr_data, o_wreg_data, o_ptr_data;
  logic [3:0]      o_wreg_sel, o_ptr_sel, mem_lat;
  logic [31:0]     seed;
  int              err_count, tests_run, cyc;

  btse_exec u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_source_work_register(i_source_work_register),
    .i_next_two_word(i_next_two_word), .i_data_read_page_register(i_data_read_page_register),
    .o_ready(o_ready), .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_rd_valid(i_rd_valid),
    .i_rd_data(i_rd_data), .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_be(o_wr_be),
    .o_wr_data(o_wr_data), .o_wreg_we(o_wreg_we), .o_wreg_sel(o_wreg_sel),
    .o_wreg_data(o_wreg_data), .o_ptr_we(o_ptr_we), .o_ptr_sel(o_ptr_sel),
    .o_ptr_data(o_ptr_data), .o_squash(o_squash));

  btse_mem_model #(.EA_W(EA_W)) u_mem (.i_clock(i_clock), .i_rd_req(o_rd_req),
    .i_rd_addr(o_rd_addr), .i_lat(mem_lat), .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data),
    .i_wr_en(o_wr_en), .i_wr_addr(o_wr_addr), .i_wr_be(o_wr_be), .i_wr_data(o_wr_data));

  initial i_clock = 1'b0;
  always #2.5 i_clock = ~i_clock;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [23:0] f_ins(logic [7:0] op, logic [12:0] f, logic [3:0] b);
    return {op, b[2:0], f[12:1], b[3]};
  endfunction : f_ins

  function automatic logic [23:0] r_ins(logic [7:0] op, logic [3:0] b, logic byt,
                                        logic [2:0] m, logic [3:0] s);
    return {op, b, 1'b0, byt, 3'b000, m, s};
  endfunction : r_ins

  function automatic btse_exp_t calc(logic [23:0] ins, logic [15:0] w, logic [9:0] pg,
                                     logic [15:0] mw);
    btse_exp_t   e;
    logic [7:0]  op;
    logic [2:0]  m;
    logic        byt;
    logic [15:0] st, eff, t;
    logic [3:0]  b;
    e   = '0;
    op  = ins[23:16];
    m   = ins[6:4];
    byt = ins[10] && (op == btse_pkg::OP_TOG_WREG);
    st  = byt ? btse_pkg::STEP_BYTE : btse_pkg::STEP_WORD;
    e.ok  = op inside {btse_pkg::OP_TOG_FILE, btse_pkg::OP_TOG_WREG,
                       btse_pkg::OP_SKC_FILE, btse_pkg::OP_SKC_WREG};
    e.skp = (op == btse_pkg::OP_SKC_FILE) || (op == btse_pkg::OP_SKC_WREG);
    e.be  = btse_pkg::BE_WORD;
    if ((op == btse_pkg::OP_TOG_FILE) || (op == btse_pkg::OP_SKC_FILE))
    begin
      e.mem  = 1'b1;
      e.addr = {12'h000, ins[12:1], 1'b0};
      b      = {ins[0], ins[15:13]};
    end
    else
    begin
      e.mem = (m != btse_pkg::AM_DIRECT);
      eff   = (m == btse_pkg::AM_PREDEC) ? w - st : (m == btse_pkg::AM_PREINC) ? w + st : w;
      e.ptr = m inside {[3'h2:3'h5]};
      e.pdat = (m == btse_pkg::AM_POSTDEC) ? w - st : (m == btse_pkg::AM_POSTINC) ? w + st : eff;
      e.addr = eff[15] ? {pg, eff[14:0]} : {9'h000, eff};
      b = byt ? {e.mem & eff[0], ins[14:12]} : ins[15:12];
      if (byt && e.mem)
        e.be = eff[0] ? btse_pkg::BE_HI : btse_pkg::BE_LO;
    end
    t      = e.mem ? mw : w;
    e.wdat = t ^ (btse_pkg::BIT_ONE << b);
    e.clr  = ~t[b];
    return e;
  endfunction : calc

  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end

  // ==========================================================================
  // One instruction, offered at a falling edge, checked when the unit is free
  task automatic run_one(logic [23:0] ins, logic [15:0] w, logic [9:0] pg, logic [15:0] mw,
                         logic two, int lat);
    btse_exp_t       e;
    int              k, busy, n_rd, n_wr, n_wreg, n_ptr, n_sq, sq;
    logic [EA_W-1:0] ra, wa;
    logic [1:0]      wb;
    logic [15:0]     wd, gd, pd;
    logic [3:0]      gs, ps;
    e = calc(ins, w, pg, mw);
    {busy, n_rd, n_wr, n_wreg, n_ptr, n_sq} = '0;
    if (rnd() % 4 == 0)
    begin
      i_instr_valid = 1'b0;
      @(negedge i_clock);
    end
    i_instr_valid = 1'b1;
    i_instr = ins;
    i_source_work_register = w;
    i_data_read_page_register = pg;
    i_next_two_word = two;
    mem_lat = lat[3:0];
    #1 u_mem.mem[e.addr[12:1]] = mw;
    @(posedge i_clock);
    for (k = 0; k < 40; k++)
    begin
      @(negedge i_clock);
      if (o_rd_req === 1'b1) begin n_rd++; ra = o_rd_addr; end
      if (o_wr_en === 1'b1) begin n_wr++; wa = o_wr_addr; wb = o_wr_be; wd = o_wr_data; end
      if (o_wreg_we === 1'b1) begin n_wreg++; gs = o_wreg_sel; gd = o_wreg_data; end
      if (o_ptr_we === 1'b1) begin n_ptr++; ps = o_ptr_sel; pd = o_ptr_data; end
      if (o_squash === 1'b1) n_sq++;
      if (o_ready === 1'b1) break;
      busy++;
      // Offers while busy must be ignored
      i_instr = {btse_pkg::OP_TOG_WREG, 16'(rnd())};
    end
    if (k == 40) begin err_count++; end_of_test(); end
    if (!e.ok)
      `CHK(n_rd + n_wr + n_wreg + n_ptr + n_sq + busy, 0)
    else
    begin
      `CHK(n_rd, int'(e.mem))
      if (e.mem) `CHK(ra, e.addr)
      `CHK(n_ptr, int'(e.ptr))
      if (e.ptr) `CHK(ps, ins[3:0])
      if (e.ptr) `CHK(pd, e.pdat)
      if (e.skp)
      begin
        sq = e.clr ? (two ? 2 : 1) : 0;
        `CHK(n_wr + n_wreg, 0)
        `CHK(n_sq, sq)
        `CHK(busy, sq + (e.mem ? lat + 1 : 0))
      end
      else if (e.mem)
      begin
        `CHK(n_wr + n_wreg, 1)
        `CHK(wa, e.addr)
        `CHK(wb, e.be)
        `CHK(wd, e.wdat)
        `CHK(busy, lat + 1)
      end
      else
      begin
        `CHK(n_wreg + n_wr, 1)
        `CHK(gs, ins[3:0])
        `CHK(gd, e.wdat)
        `CHK(busy, 0)
      end
    end
  endtask : run_one

  // ==========================================================================
  // Main sequence
  logic [7:0]  ops [5];
  logic [31:0] r, r2;
  logic [7:0]  op;
  logic        byt;
  logic [3:0]  b;
  logic [15:0] w;

  initial
  begin
    ops = '{btse_pkg::OP_TOG_FILE, btse_pkg::OP_TOG_WREG, btse_pkg::OP_SKC_FILE,
            btse_pkg::OP_SKC_WREG, 8'hae};
    seed = 32'h0000_72ee;
    {err_count, tests_run, cyc} = '0;
    {i_rst_n, i_instr_valid, i_next_two_word, i_instr} = '0;
    {i_source_work_register, i_data_read_page_register, mem_lat} = '0;
    repeat (8) @(posedge i_clock);
    @(negedge i_clock) i_rst_n = 1'b1;
    @(negedge i_clock);
    run_one(f_ins(btse_pkg::OP_TOG_FILE, 13'h0000, 4'h0), 16'h0000, 10'h000, 16'hffff, 0, 1);
    run_one(f_ins(btse_pkg::OP_TOG_FILE, 13'h1ffe, 4'hf), 16'h0000, 10'h000, 16'h0001, 0, 2);
    run_one(f_ins(btse_pkg::OP_TOG_FILE, 13'h1660, 4'h8), 16'h0000, 10'h000, 16'h5606, 0, 1);
    run_one(r_ins(btse_pkg::OP_TOG_WREG, 4'h0, 0, 3'h0, 4'h2), 16'hf234, 10'h000, 16'h0, 0, 1);
    run_one(r_ins(btse_pkg::OP_TOG_WREG, 4'h0, 0, 3'h3, 4'h0), 16'h2300, 10'h000, 16'h5606, 0, 1);
    run_one(r_ins(btse_pkg::OP_TOG_WREG, 4'h4, 1, 3'h1, 4'h1), 16'h1001, 10'h000, 16'hf234, 0, 3);
    run_one(r_ins(btse_pkg::OP_SKC_WREG, 4'h0, 0, 3'h0, 4'h0), 16'h264f, 10'h000, 16'h0, 1, 1);
    run_one(r_ins(btse_pkg::OP_SKC_WREG, 4'hf, 0, 3'h0, 4'h6), 16'h264f, 10'h000, 16'h0, 1, 1);
    run_one(r_ins(btse_pkg::OP_SKC_WREG, 4'hc, 0, 3'h3, 4'h6), 16'h1800, 10'h000, 16'h1000, 0, 1);
    run_one(f_ins(btse_pkg::OP_SKC_FILE, 13'h0804, 4'he), 16'h0000, 10'h000, 16'h2647, 1, 6);
    run_one(r_ins(btse_pkg::OP_TOG_WREG, 4'h3, 0, 3'h4, 4'h5), 16'h8002, 10'h155, 16'h0, 0, 2);
    run_one(24'ha8_0000, 16'h0000, 10'h000, 16'h0000, 0, 1);
    repeat (300)
    begin
      r = rnd();
      r2 = rnd();
      op = ops[r % 5];
      byt = (op == btse_pkg::OP_TOG_WREG) && r[0];
      b = byt ? {1'b0, r[10:8]} : r[11:8];
      w = r[31:16];
      if (!byt && r[3:1] != 3'h0) w[0] = 1'b0;
      if (op == btse_pkg::OP_TOG_FILE || op == btse_pkg::OP_SKC_FILE)
        run_one(f_ins(op, {r[24:13], 1'b0}, b), w, r2[9:0], r2[31:16], r2[10], 1 + r2[12:11]);
      else
        run_one(r_ins(op, b, byt, r[3:1], r[7:4]), w, r2[9:0], r2[31:16], r2[10],
                1 + r2[12:11]);
    end
    end_of_test();
  end

endmodule : test_bit_toggle_skip_exec

`default_nettype wire
